// File: rtl/swhr_params.svh
`ifndef SWHR_PARAMS_SVH
`define SWHR_PARAMS_SVH
// data address of the flag register
`define SWHR_FLAG_ADDR      8'h0a
// flag bit positions
`define SWHR_BIT_CARRY      0
`define SWHR_BIT_HALF       1
`define SWHR_BIT_ZERO       2
`define SWHR_BIT_OVF        3
`define SWHR_BIT_PDOWN      4
`define SWHR_BIT_TOUT       5
// instruction clock is system clock divided by four
`define SWHR_ICLK_DIV       4
// start-up delay in system clock periods
`define SWHR_STARTUP_CYCLES 1024
// port and program counter reset values
`define SWHR_PORT_RESET     8'hff
`define SWHR_PC_RESET       10'h000
`endif

// File: rtl/swhr_pkg.sv
package swhr_pkg;
    // alu operation classes reported by the core
    typedef enum logic [2:0] {
        SWHR_OP_NONE,
        SWHR_OP_ADD,
        SWHR_OP_SUB,
        SWHR_OP_LOGIC,
        SWHR_OP_ROT_C
    } swhr_op_t;
    // sequencer states
    typedef enum logic [1:0] {
        SWHR_ST_STARTUP,
        SWHR_ST_RUN,
        SWHR_ST_HALT
    } swhr_state_t;
endpackage

// File: rtl/swhr_core.sv
`timescale 1ns/1ps
`include "swhr_params.svh"
// How it works
// - flag register at 0ah: c, half, z, ovf, powerdown, timeout; bits 6,7 zero
// - writes change arithmetic flags only; powerdown and timeout ignore data
// - carry set on add carry or subtract no-borrow; rotate-through-carry updates it
// - half-carry set on low-nibble carry or no nibble borrow in subtract
// - zero flag set when an add, subtract or logic result is zero; rotate leaves it
// - overflow set when carry into msb differs from carry out
// - powerdown cleared by power-up or watchdog clear, set by halt
// - timeout cleared by power-up, watchdog clear or halt; set on timeout
// - subroutine call never saves or touches the flags
// - watchdog counts instruction clocks, times out after 2^n, n 8 to 11
// - watchdog disabled option makes clear ops no-ops and no timeout
// - watchdog overflow in run resets chip and sets timeout flag
// - prescaler cleared by reset pin low, clear sequence, or halt
// - single mode clears on one op; double mode needs both ops
// - halt stops clock, clears prescaler, sets pd, clears to; watchdog keeps counting
// - halt ends on reset pin or enabled port b falling edge
// - watchdog timeout in halt wakes, sets timeout, resets pc and sp only
// - wake-up waits 1024 system clocks before execution resumes
// - reset source coded in timeout and powerdown flags
// - resets load pc 000h, ports all ones, except timeout during halt
// - start-up delay on power-up, wake and run timeout, none for reset pin in run
// - chip reset clears prescaler, ports input, sp top, carrier low
module swhr_core #(
    parameter int WDT_EXP        = 8,        // watchdog exponent 8 to 11
    parameter bit WDT_ENABLE     = 1'b1,
    parameter bit WDT_DOUBLE_CLR = 1'b0,
    parameter logic [7:0] WAKE_EN = 8'hff,
    parameter int STARTUP_CYCLES = `SWHR_STARTUP_CYCLES
) (
    input  wire logic              ref_clk_in,
    input  wire logic              nrst_in,
    input  wire logic              clk_en_in,
    input  wire logic              external_clear_n_in,
    input  wire logic [7:0]        port_b_in,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [7:0]        reg_rdata_out,
    input  wire swhr_pkg::swhr_op_t alu_op_in,
    input  wire logic [7:0]        alu_a_in,
    input  wire logic [7:0]        alu_b_in,
    input  wire logic [7:0]        alu_result_in,
    input  wire logic              rot_carry_in,
    input  wire logic              halt_op_in,
    input  wire logic              watchdog_clear_op_in,
    input  wire logic              watchdog_clear_first_op_in,
    input  wire logic              watchdog_clear_second_op_in,
    output logic                   chip_reset_out,
    output logic                   pc_sp_reset_out,
    output logic                   port_reset_out,
    output logic                   core_run_out,
    output logic                   halted_out,
    output logic                   wake_resume_out,
    output logic [7:0]             flags_out
);

    // counter widths cover the longest timeout and the start-up count
    localparam int WDT_W = 12;
    localparam int SST_W = 11;
    localparam logic [SST_W-1:0] SST_LAST = SST_W'(STARTUP_CYCLES - 1);
    localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'((1 << WDT_EXP) - 1);

    // all state of the block in one record
    typedef struct packed {
        swhr_pkg::swhr_state_t state;
        logic [1:0]         ext_sync;
        logic [7:0]         pb_s1;
        logic [7:0]         pb_s2;
        logic [7:0]         pb_prev;
        logic [1:0]         div4;
        logic [WDT_W-1:0]   wdt_cnt;
        logic [SST_W-1:0]   sst_cnt;
        logic               clr_first_seen;
        logic               clr_second_seen;
        logic               carry;
        logic               half;
        logic               zero;
        logic               ovf;
        logic               pdown;
        logic               tout;
        logic               chip_rst;
        logic               pcsp_rst;
        logic               port_rst;
        logic               wake_pulse;
        logic [7:0]         rdata;
    } swhr_regs_t;

    swhr_regs_t r;
    swhr_regs_t next_r;

    // decoded events of the current cycle
    logic       ext_low;
    logic       pb_fall;
    logic       clr_done;
    logic       wdt_tick;
    logic       wdt_ovf;
    logic [8:0] add_sum;
    logic [4:0] add_nib;
    logic [7:0] add_low;
    logic [7:0] sub_b;
    logic [7:0] flag_word;

    // arithmetic helpers shared by the flag logic
    always_comb
    begin
        sub_b   = ~alu_b_in;
        add_sum = {1'b0, alu_a_in} + {1'b0, alu_b_in};
        add_nib = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]};
        add_low = {1'b0, alu_a_in[6:0]} + {1'b0, alu_b_in[6:0]};
        if (alu_op_in == swhr_pkg::SWHR_OP_SUB)
        begin
            // a - b as a + ~b + 1, carry out means no borrow
            add_sum = {1'b0, alu_a_in} + {1'b0, sub_b} + 9'h001;
            add_nib = {1'b0, alu_a_in[3:0]} + {1'b0, sub_b[3:0]} + 5'h01;
            add_low = {1'b0, alu_a_in[6:0]} + {1'b0, sub_b[6:0]} + 8'h01;
        end
    end

    // flag register image; the two top bits always read as zero
    always_comb
    begin
        flag_word                  = 8'h00;
        flag_word[`SWHR_BIT_CARRY] = r.carry;
        flag_word[`SWHR_BIT_HALF]  = r.half;
        flag_word[`SWHR_BIT_ZERO]  = r.zero;
        flag_word[`SWHR_BIT_OVF]   = r.ovf;
        flag_word[`SWHR_BIT_PDOWN] = r.pdown;
        flag_word[`SWHR_BIT_TOUT]  = r.tout;
    end

    // next-state logic for the whole block
    always_comb
    begin
        next_r   = r;
        ext_low  = ~r.ext_sync[1];
        pb_fall  = |(r.pb_prev & ~r.pb_s2 & WAKE_EN);
        clr_done = WDT_DOUBLE_CLR ?
            ((watchdog_clear_first_op_in | r.clr_first_seen) &
             (watchdog_clear_second_op_in | r.clr_second_seen) &
             (watchdog_clear_first_op_in | watchdog_clear_second_op_in)) :
            watchdog_clear_op_in;
        clr_done = clr_done & WDT_ENABLE;
        wdt_tick = (r.div4 == 2'(`SWHR_ICLK_DIV - 1));
        wdt_ovf  = WDT_ENABLE && wdt_tick && (r.wdt_cnt == WDT_LAST);

        // pins pass two flops before use; the port b edge is taken
        // only from the synchronised copies, never from the first stage
        next_r.ext_sync   = {r.ext_sync[0], external_clear_n_in};
        next_r.pb_s1      = port_b_in;
        next_r.pb_s2      = r.pb_s1;
        next_r.pb_prev    = r.pb_s2;
        next_r.div4       = r.div4 + 2'h1;
        // one-cycle pulses drop back unless set again below
        next_r.pcsp_rst   = 1'b0;
        next_r.port_rst   = 1'b0;
        next_r.wake_pulse = 1'b0;
        next_r.rdata      = 8'h00;

        // register read, data one cycle later
        if (reg_rd_in && reg_addr_in == `SWHR_FLAG_ADDR)
            next_r.rdata = flag_word;

        // software write touches arithmetic flags only
        if (reg_wr_in && reg_addr_in == `SWHR_FLAG_ADDR)
        begin
            next_r.carry = reg_wdata_in[`SWHR_BIT_CARRY];
            next_r.half  = reg_wdata_in[`SWHR_BIT_HALF];
            next_r.zero  = reg_wdata_in[`SWHR_BIT_ZERO];
            next_r.ovf   = reg_wdata_in[`SWHR_BIT_OVF];
        end

        // alu result flags; calls send no op so flags stay put
        unique case (alu_op_in)
            swhr_pkg::SWHR_OP_ADD, swhr_pkg::SWHR_OP_SUB:
            begin
                next_r.carry = add_sum[8];
                next_r.half  = add_nib[4];
                next_r.zero  = (alu_result_in == 8'h00);
                next_r.ovf   = add_low[7] ^ add_sum[8];
            end
            // logic ops leave carry, half-carry and overflow alone
            swhr_pkg::SWHR_OP_LOGIC:
                next_r.zero = (alu_result_in == 8'h00);
            swhr_pkg::SWHR_OP_ROT_C:
                next_r.carry = rot_carry_in;
            swhr_pkg::SWHR_OP_NONE:
            begin
                // no alu result: flags keep what a write left in them
            end
            default:
            begin
                // undefined op code: flags left alone
            end
        endcase

        // clear-pair tracking for double-clear mode
        // a pair split over several cycles counts once both are seen
        if (watchdog_clear_first_op_in)
            next_r.clr_first_seen = 1'b1;
        if (watchdog_clear_second_op_in)
            next_r.clr_second_seen = 1'b1;

        // watchdog counter advances on instruction clocks
        if (wdt_tick && WDT_ENABLE)
            next_r.wdt_cnt = r.wdt_cnt + WDT_W'(1);

        unique case (r.state)
            swhr_pkg::SWHR_ST_STARTUP:
            begin
                // delay keeps the core stopped; chip reset stays as entered,
                // so a port or halt-timeout wake does not reset the core,
                // while power-up, run timeout and reset pin keep it held
                next_r.chip_rst = r.chip_rst;
                next_r.wdt_cnt  = '0;
                next_r.sst_cnt  = r.sst_cnt + SST_W'(1);
                if (r.sst_cnt == SST_LAST)
                begin
                    // end of delay: core released, resume pulse issued
                    next_r.state    = swhr_pkg::SWHR_ST_RUN;
                    next_r.chip_rst = 1'b0;
                    next_r.sst_cnt  = '0;
                    next_r.wake_pulse = 1'b1;
                end
            end
            swhr_pkg::SWHR_ST_RUN:
            begin
                next_r.chip_rst = 1'b0;
                // a completed clear sequence restarts the watchdog
                if (clr_done)
                begin
                    next_r.wdt_cnt = '0;
                    next_r.pdown   = 1'b0;
                    next_r.tout    = 1'b0;
                    next_r.clr_first_seen  = 1'b0;
                    next_r.clr_second_seen = 1'b0;
                end
                // halt entry clears the prescaler and records power-down
                if (halt_op_in)
                begin
                    next_r.state   = swhr_pkg::SWHR_ST_HALT;
                    next_r.wdt_cnt = '0;
                    next_r.pdown   = 1'b1;
                    next_r.tout    = 1'b0;
                end
                if (wdt_ovf)
                begin
                    // run timeout: full reset, pdown unchanged
                    next_r.tout     = 1'b1;
                    next_r.chip_rst = 1'b1;
                    next_r.pcsp_rst = 1'b1;
                    next_r.port_rst = 1'b1;
                    next_r.wdt_cnt  = '0;
                    next_r.state    = swhr_pkg::SWHR_ST_STARTUP;
                end
            end
            swhr_pkg::SWHR_ST_HALT:
            begin
                // the watchdog keeps counting in halt, as its timeout is
                // the only wake-up that needs no pin activity
                next_r.wdt_cnt = r.wdt_cnt;
                if (WDT_ENABLE && wdt_tick)
                    next_r.wdt_cnt = r.wdt_cnt + WDT_W'(1);
                if (wdt_ovf)
                begin
                    // timeout in halt wakes, ports left alone
                    next_r.tout     = 1'b1;
                    next_r.pcsp_rst = 1'b1;
                    next_r.wdt_cnt  = '0;
                    next_r.state    = swhr_pkg::SWHR_ST_STARTUP;
                end
                else if (pb_fall)
                    next_r.state = swhr_pkg::SWHR_ST_STARTUP;
            end
            default:
            begin
                // stray state code: restart through a held start-up delay
                next_r.state    = swhr_pkg::SWHR_ST_STARTUP;
                next_r.chip_rst = 1'b1;
            end
        endcase

        // reset pin: no start-up delay in run, wakes from halt with delay
        if (ext_low)
        begin
            next_r.wdt_cnt         = '0;
            next_r.chip_rst        = 1'b1;
            next_r.pcsp_rst        = 1'b1;
            next_r.port_rst        = 1'b1;
            next_r.clr_first_seen  = 1'b0;
            next_r.clr_second_seen = 1'b0;
            // pin low in halt is a wake with delay; pin held low during a
            // delay restarts it, so the full delay follows the release
            if (r.state == swhr_pkg::SWHR_ST_HALT)
            begin
                next_r.tout  = 1'b0;
                next_r.pdown = 1'b1;
                next_r.state = swhr_pkg::SWHR_ST_STARTUP;
                next_r.sst_cnt = '0;
            end
            else if (r.state == swhr_pkg::SWHR_ST_RUN)
                next_r.state = swhr_pkg::SWHR_ST_RUN;
            else if (r.state == swhr_pkg::SWHR_ST_STARTUP)
                next_r.sst_cnt = '0;
        end
    end

    // state register; power-up lands in start-up with both flags low
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            r          <= '0;
            r.state    <= swhr_pkg::SWHR_ST_STARTUP;
            // pins idle high, so no false edge follows reset
            r.ext_sync <= 2'b11;
            r.pb_s1    <= 8'hff;
            r.pb_s2    <= 8'hff;
            r.pb_prev  <= 8'hff;
            r.chip_rst <= 1'b1;
            r.pcsp_rst <= 1'b1;
            r.port_rst <= 1'b1;
            r.pdown    <= 1'b0;
            r.tout     <= 1'b0;
        end
        else if (clk_en_in)
            r <= next_r;
    end

    // outputs taken or decoded from flops only, with no path from an input
    assign reg_rdata_out   = r.rdata;
    assign chip_reset_out  = r.chip_rst;
    assign pc_sp_reset_out = r.pcsp_rst | r.chip_rst;
    assign port_reset_out  = r.port_rst;
    assign core_run_out    = (r.state == swhr_pkg::SWHR_ST_RUN) & ~r.chip_rst;
    assign halted_out      = (r.state == swhr_pkg::SWHR_ST_HALT);
    assign wake_resume_out = r.wake_pulse;
    assign flags_out       = flag_word;

endmodule // swhr_core

// File: sim/swhr_core_sva.sv
`timescale 1ns/1ps
module swhr_core_sva (
    input wire logic               ref_clk_in,
    input wire logic               nrst_in,
    input wire logic               clk_en_in,
    input wire logic               external_clear_n_in,
    input wire logic [7:0]         reg_addr_in,
    input wire logic [7:0]         reg_wdata_in,
    input wire logic               reg_wr_in,
    input wire logic               reg_rd_in,
    input wire logic [7:0]         reg_rdata_out,
    input wire swhr_pkg::swhr_op_t alu_op_in,
    input wire logic [7:0]         alu_a_in,
    input wire logic [7:0]         alu_b_in,
    input wire logic               halt_op_in,
    input wire logic               watchdog_clear_op_in,
    input wire logic               chip_reset_out,
    input wire logic               core_run_out,
    input wire logic               halted_out,
    input wire logic [7:0]         flags_out
);
    logic [8:0] sum;
    // carry out of an unsigned add of the operands
    assign sum = {1'b0, alu_a_in} + {1'b0, alu_b_in};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // register port, flag register, halt, clear and reset pin behaviour
    property p_rd_flags;
        reg_rd_in && reg_addr_in == 8'h0a |=> reg_rdata_out == $past(flags_out);
    endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("flag read data wrong");
    property p_rd_other;
        reg_rd_in && reg_addr_in != 8'h0a |=> reg_rdata_out == 8'h00;
    endproperty
    a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");
    property p_top_zero;
        flags_out[7:6] == 2'b00;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("unused flag bits set");
    property p_wr_keep;
        clk_en_in && reg_wr_in && reg_addr_in == 8'h0a && alu_op_in == swhr_pkg::SWHR_OP_NONE
        && !halt_op_in && !watchdog_clear_op_in && !chip_reset_out
        |=> flags_out == {2'b00, $past(flags_out[5:4]), $past(reg_wdata_in[3:0])};
    endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("flag write wrong");
    property p_add_c;
        alu_op_in == swhr_pkg::SWHR_OP_ADD && core_run_out |=> flags_out[0] == $past(sum[8]);
    endproperty
    a_add_c: assert property (p_add_c) else $error("add carry wrong");
    property p_halt;
        halt_op_in && core_run_out |=> halted_out && flags_out[5:4] == 2'b01;
    endproperty
    a_halt: assert property (p_halt) else $error("halt entry wrong");
    property p_clr;
        watchdog_clear_op_in && core_run_out |=> flags_out[5:4] == 2'b00;
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not drop flags");
    property p_ext;
        !external_clear_n_in [*4] |-> chip_reset_out;
    endproperty
    a_ext: assert property (p_ext) else $error("reset pin ignored");
    property p_excl;
        chip_reset_out |-> !core_run_out && !halted_out;
    endproperty
    a_excl: assert property (p_excl) else $error("core runs in reset");
endmodule // swhr_core_sva

// File: sim/swhr_core_model.sv
`timescale 1ns/1ps
module swhr_core_model (
    input  wire logic ref_clk_in,
    input  wire logic core_run_in,
    output logic      halt_op_out,
    output logic      clear_op_out,
    output logic      clear_first_op_out,
    output logic      clear_second_op_out
);
    initial {halt_op_out, clear_op_out, clear_first_op_out, clear_second_op_out} = 4'h0;
    // one instruction pulse, only issued while the core may execute
    task automatic issue(input int kind);
        do
            @(posedge ref_clk_in);
        while (core_run_in !== 1'b1);
        case (kind)
            0: halt_op_out <= 1'b1;
            1: clear_op_out <= 1'b1;
            default:
            begin
                clear_first_op_out <= 1'b1;
                clear_second_op_out <= 1'b1;
            end
        endcase
        @(posedge ref_clk_in);
        {halt_op_out, clear_op_out, clear_first_op_out, clear_second_op_out} <= 4'h0;
    endtask
endmodule // swhr_core_model

// File: sim/tb_swhr_core.sv
`timescale 1ns/1ps
module tb_swhr_core;
    localparam int SU = 16;
    logic clk = 0, nrst = 0, xclr_n = 1, wr = 0, rd = 0, rotc = 0, cen = 1;
    logic [7:0] pb = 8'hff, addr = 0, wdat = 0, a = 0, b = 0, res = 0, rdat, flags;
    swhr_pkg::swhr_op_t op = swhr_pkg::SWHR_OP_NONE;
    logic halt, clr, clr1, clr2, crst, pcsp, prst, run, hlt, wres;
    int fails = 0, n_checks = 0, prst_seen = 0, pcsp_seen = 0, n, p0, q0;
    swhr_core #(.WDT_EXP(8), .STARTUP_CYCLES(SU)) swhr_core_inst (
        .ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(cen), .external_clear_n_in(xclr_n),
        .port_b_in(pb), .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdat), .alu_op_in(op), .alu_a_in(a), .alu_b_in(b),
        .alu_result_in(res), .rot_carry_in(rotc), .halt_op_in(halt),
        .watchdog_clear_op_in(clr), .watchdog_clear_first_op_in(clr1),
        .watchdog_clear_second_op_in(clr2), .chip_reset_out(crst), .pc_sp_reset_out(pcsp),
        .port_reset_out(prst), .core_run_out(run), .halted_out(hlt),
        .wake_resume_out(wres), .flags_out(flags));
    swhr_core_model swhr_core_model_inst (.ref_clk_in(clk), .core_run_in(run),
        .halt_op_out(halt), .clear_op_out(clr), .clear_first_op_out(clr1),
        .clear_second_op_out(clr2));
    // clock and reset pulse counters
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (prst === 1'b1) prst_seen++;
        if (pcsp === 1'b1) pcsp_seen++;
    end
    task automatic complete_run;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int v, lo, hi);
        chk({7'h0, v >= lo && v <= hi}, 8'h01);
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int c);
        c = 0;
        while (s !== 1'b1 && c < lim)
        begin
            @(posedge clk);
            #1 c++;
        end
    endtask
    task automatic reg_acc(input logic w, input logic [7:0] ad, d);
        @(posedge clk);
        addr <= ad;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 if (!w) chk(rdat, d);
    endtask
    task automatic alu_run(input swhr_pkg::swhr_op_t o, input logic [7:0] x, y, r,
                           input logic rc);
        @(posedge clk);
        {op, a, b, res, rotc} <= {o, x, y, r, rc};
        @(posedge clk);
        op <= swhr_pkg::SWHR_OP_NONE;
        #1;
    endtask
    // expected {ovf, zero, half, carry} of an add or subtract
    function automatic logic [3:0] arith(input logic sub, input logic [7:0] x, y);
        logic [8:0] s;
        logic [4:0] lo;
        logic [7:0] m, yy;
        yy = sub ? ~y : y;
        s = {1'b0, x} + {1'b0, yy} + 9'(sub);
        lo = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(sub);
        m = {1'b0, x[6:0]} + {1'b0, yy[6:0]} + 8'(sub);
        return {m[7] ^ s[8], s[7:0] == 8'h00, lo[4], s[8]};
    endfunction
    task automatic t_regs_alu;
        logic [7:0] xs [6] = '{8'h80, 8'h0f, 8'h7f, 8'h10, 8'h05, 8'h03};
        logic [7:0] ys [6] = '{8'h80, 8'h01, 8'h01, 8'h01, 8'h05, 8'h07};
        reg_acc(1, 8'h0a, 8'hff);
        reg_acc(0, 8'h0a, 8'h0f);
        reg_acc(1, 8'h0b, 8'h00);
        reg_acc(0, 8'h0b, 8'h00);
        reg_acc(0, 8'h0a, 8'h0f);
        // a write while the clock enable is low must not land
        @(posedge clk) cen <= 1'b0;
        reg_acc(1, 8'h0a, 8'h00);
        @(posedge clk) cen <= 1'b1;
        reg_acc(0, 8'h0a, 8'h0f);
        for (int s = 0; s < 2; s++)
            for (int i = 0; i < 6; i++)
            begin
                alu_run(s ? swhr_pkg::SWHR_OP_SUB : swhr_pkg::SWHR_OP_ADD, xs[i], ys[i],
                        s ? xs[i] - ys[i] : xs[i] + ys[i], 1'b0);
                chk({4'h0, flags[3:0]}, {4'h0, arith(s[0], xs[i], ys[i])});
            end
        for (int i = 0; i < 2; i++)
        begin
            alu_run(swhr_pkg::SWHR_OP_LOGIC, 8'h0f, 8'hf0, 8'(i), 1'b0);
            chk(flags & 8'h04, i ? 8'h00 : 8'h04);
            alu_run(swhr_pkg::SWHR_OP_ROT_C, 8'h00, 8'h00, 8'h02, !i);
            chk(flags & 8'h01, 8'(!i));
        end
    endtask
    task automatic t_wdog;
        for (int i = 0; i < 5; i++)
        begin
            swhr_core_model_inst.issue(1);
            repeat (700) @(posedge clk);
        end
        #1 chk(flags & 8'h30, 8'h00);
        // the pair ops do not clear in single-clear mode, so the timeout
        // still comes 1021 to 1024 cycles after the last single clear
        swhr_core_model_inst.issue(2);
        p0 = prst_seen;
        wait_hi(crst, 1100, n);
        chk_in(n, 315, 325);
        chk(flags & 8'h30, 8'h20);
        wait_hi(run, 2000, n);
        chk_in(prst_seen - p0, 1, 2);
    endtask
    task automatic t_halt(input logic by_port);
        swhr_core_model_inst.issue(1);
        swhr_core_model_inst.issue(0);
        #1 chk({hlt, 1'b0, flags[5:4], 4'h0}, 8'h90);
        p0 = prst_seen;
        q0 = pcsp_seen;
        if (by_port)
        begin
            @(posedge clk) pb <= 8'hfe;
            wait_hi(wres, 60, n);
            chk_in(n, SU, SU + 8);
            chk(flags & 8'h30, 8'h10);
            chk_in(prst_seen - p0, 0, 0);
            chk_in(pcsp_seen - q0, 0, 0);
            @(posedge clk) pb <= 8'hff;
        end
        else
        begin
            wait_hi(pcsp, 1100, n);
            chk_in(n, 990, 1030);
            chk(flags & 8'h30, 8'h30);
            wait_hi(run, 100, n);
            chk_in(prst_seen - p0, 0, 0);
            chk_in(pcsp_seen - q0, 1, 1);
        end
        wait_hi(run, 100, n);
    endtask
    task automatic t_ext(input logic in_halt);
        if (in_halt)
        begin
            swhr_core_model_inst.issue(1);
            swhr_core_model_inst.issue(0);
        end
        @(posedge clk) xclr_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk({7'h0, crst}, 8'h01);
        @(posedge clk) xclr_n <= 1'b1;
        wait_hi(run, 100, n);
        chk_in(n, in_halt ? SU : 0, in_halt ? SU + 12 : 8);
        chk(flags & 8'h30, in_halt ? 8'h10 : 8'h30);
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(flags, 8'h00);
        wait_hi(run, 100, n);
        chk_in(n, SU - 2, SU + 4);
        t_regs_alu;
        t_wdog;
        t_halt(1);
        t_halt(0);
        t_ext(0);
        t_ext(1);
        complete_run;
    end
    // watchdog on the run itself
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run;
    end
endmodule // tb_swhr_core
bind swhr_core swhr_core_sva swhr_core_sva_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .clk_en_in(clk_en_in),
    .external_clear_n_in(external_clear_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .alu_op_in(alu_op_in), .alu_a_in(alu_a_in),
    .alu_b_in(alu_b_in), .halt_op_in(halt_op_in), .watchdog_clear_op_in(watchdog_clear_op_in),
    .chip_reset_out(chip_reset_out), .core_run_out(core_run_out), .halted_out(halted_out),
    .flags_out(flags_out));
